// ==== absft_timing.sv ====
// Purpose: Superframe timer, framer and TDM slot mapper for one bus node
// Assumes: Link logic runs on the bus clock, user side on clk
// Notes:   Config is static while running; words cross via a gray FIFO
`timescale 1ns/1ps
`default_nettype none
// Operation
// - New superframe every 1024 bus clocks
// - Control frame, data slots, response frame
// - Master sends preamble every superframe
// - Slave locks to preamble, aligned clock
// - Last node answers after response time
// - All nodes share the response time
// - Channel length 16 or 32 bit clocks
// - Up to 32 channels, one stream
// - Data exchanged at 44.1 or 48 kHz
// - Slots follow control and response frames
// - Equal slot widths per direction
// - Downstream, upstream and idle periods
module absft_timing
(
	input  wire logic                clk,          // User clock, 125 MHz
	input  wire logic                rst,          // Async reset, high
	input  wire logic                bclk,         // Bus clock from host
	input  wire absft_pkg::absft_cfg_t cfg,        // Static configuration
	input  wire logic                fsync,        // Host frame sync, bclk domain
	input  wire logic                line_in,      // Received line bit, bclk domain
	output logic                     line_out,     // Transmitted line bit
	output logic                     line_oe,      // High while node drives line
	input  wire logic                tx_valid,     // User word offered
	output logic                     tx_ready,     // Buffer accepts word
	input  wire absft_pkg::absft_word_t tx_word,   // User word for bus
	output logic                     rx_valid,     // Word from bus available
	input  wire logic                rx_ready,     // User takes word
	output absft_pkg::absft_word_t   rx_word,      // Word from bus
	output logic                     locked,       // Node in superframe lock
	output logic                     sf_start,     // One clk pulse per superframe
	output logic                     frame_rate    // Selected frame rate, echoed
);
	// ----------------------------------------
	// Bus clock domain state
	// ----------------------------------------
	typedef struct packed {
		logic [9:0]                  cnt;       // Position in superframe
		absft_pkg::absft_phase_t     ph;        // Current period
		logic [15:0]                 pre_sh;    // Preamble shift register
		logic [3:0]                  seen;      // Preambles seen in place
		logic                        lock;      // Aligned to master
		logic                        fs_q;      // Last frame sync
		logic                        sf_tgl;    // Toggles per superframe
		logic [5:0]                  bit_i;     // Bit within slot
		logic [5:0]                  slot_i;    // Slot within direction
		logic [31:0]                 sh;        // Slot shift register
		logic                        out;       // Line bit
		logic                        oe;        // Line enable
		logic [2:0]                  wp;        // Rx FIFO write pointer, binary
		logic [2:0]                  rp;        // Tx FIFO read pointer, binary
		logic [2:0]                  wp_g;      // Rx write pointer, gray, from a flop
		logic [2:0]                  rp_g;      // Tx read pointer, gray, from a flop
		absft_pkg::absft_word_t      cur;       // Word being sent
	} bstate_t;

	bstate_t b_reg;                              // Registered bus state
	bstate_t b_next;                             // Next bus state

	// Two-entry FIFO storage, one per direction
	absft_pkg::absft_word_t txm [0:1];           // User to bus
	absft_pkg::absft_word_t rxm [0:1];           // Bus to user

	// ----------------------------------------
	// User clock domain state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]             twp;      // Tx write pointer, binary
		logic [2:0]             rrp;      // Rx read pointer, binary
		logic [2:0]             twp_g;    // Tx write pointer, gray, from a flop
		logic [2:0]             rrp_g;    // Rx read pointer, gray, from a flop
		logic [2:0]             rwp_s1;   // Rx write gray, stage 1
		logic [2:0]             rwp_s2;   // Rx write gray, stage 2
		logic [2:0]             trp_s1;   // Tx read gray, stage 1
		logic [2:0]             trp_s2;   // Tx read gray, stage 2
		logic                   tg_s1;    // Superframe toggle, stage 1
		logic                   tg_s2;    // Superframe toggle, stage 2
		logic                   tg_s3;    // Edge detect history
		logic                   lk_s1;    // Lock level, stage 1
		logic                   lk_s2;    // Lock level, stage 2
		absft_pkg::absft_word_t rw;       // Output word register
		logic                   rv;       // Output word valid
	} ustate_t;

	ustate_t u_reg;                              // Registered user state
	ustate_t u_next;                             // Next user state

	// Gray helpers for pointer crossing
	function automatic logic [2:0] bin2gray(input logic [2:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [2:0] gray2bin(input logic [2:0] g);
		gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
	endfunction

	// Pointers seen across the crossing, bus side (2 flops)
	logic [2:0] twp_g_s1;                        // Tx write gray, stage 1
	logic [2:0] twp_g_s2;                        // Tx write gray, stage 2
	logic [2:0] rrp_g_s1;                        // Rx read gray, stage 1
	logic [2:0] rrp_g_s2;                        // Rx read gray, stage 2
	logic [1:0] fs_sync;                         // Frame sync synchroniser
	logic [1:0] li_sync;                         // Line input synchroniser

	// ----------------------------------------
	// Bus side synchronisers
	// ----------------------------------------
	// Pins and user pointers pass two flops before use
	always_ff @(posedge bclk or posedge rst)
	begin
		if (rst)
		begin
			twp_g_s1 <= 3'h0;
			twp_g_s2 <= 3'h0;
			rrp_g_s1 <= 3'h0;
			rrp_g_s2 <= 3'h0;
			fs_sync  <= 2'h0;
			li_sync  <= 2'h0;
		end
		else
		begin
			twp_g_s1 <= u_reg.twp_g;
			twp_g_s2 <= twp_g_s1;
			rrp_g_s1 <= u_reg.rrp_g;
			rrp_g_s2 <= rrp_g_s1;
			fs_sync  <= {fs_sync[0], fsync};
			li_sync  <= {li_sync[0], line_in};
		end
	end

	// ----------------------------------------
	// Bus side framer
	// ----------------------------------------
	logic [2:0] twp_b;                           // Tx write pointer in bclk
	logic [2:0] rrp_b;                           // Rx read pointer in bclk
	logic       tx_have;                         // Tx FIFO not empty
	logic       rx_room;                         // Rx FIFO not full
	logic [5:0] slot_w;                          // Width for active direction
	logic [5:0] slot_n;                          // Slots for active direction
	logic [9:0] resp_end;                        // End of response frame
	logic       pre_hit;                         // Preamble just matched

	always_comb
	begin
		twp_b    = gray2bin(twp_g_s2);
		rrp_b    = gray2bin(rrp_g_s2);
		tx_have  = (twp_b != b_reg.rp);
		rx_room  = (3'(b_reg.wp - rrp_b) != 3'h2); // Two words in flight means full
		resp_end = 10'(cfg.resp_time + absft_pkg::RESP_LEN);
		pre_hit  = (b_reg.pre_sh == absft_pkg::PREAMBLE_WORD);
		// Channel length picks the slot width per direction
		if (b_reg.ph == absft_pkg::PH_UP)
		begin
			slot_w = cfg.ch32 ? cfg.up_slot_w : absft_pkg::BITS16;
			slot_n = cfg.up_slots;
		end
		else
		begin
			slot_w = cfg.ch32 ? cfg.dn_slot_w : absft_pkg::BITS16;
			slot_n = cfg.dn_slots;
		end
		// Slot count clamps at CH_MAX, 32 channels; dual16 is not decoded
		if (slot_n > absft_pkg::CH_MAX)
			slot_n = absft_pkg::CH_MAX;
	end

	// Next state of the whole bus side
	always_comb
	begin
		b_next        = b_reg;
		b_next.fs_q   = fs_sync[1];
		b_next.pre_sh = {b_reg.pre_sh[14:0], li_sync[1]};
		b_next.cnt    = 10'(b_reg.cnt + 10'h001); // Free-run over 1024
		b_next.oe     = 1'b0;
		b_next.out    = 1'b0;
		// Master restarts on host frame sync edge
		if (cfg.master && fs_sync[1] && !b_reg.fs_q)
			b_next.cnt = 10'h000;
		if (cfg.master)
			b_next.lock = 1'b1;
		// Slave aligns its counter to the preamble
		if (!cfg.master && pre_hit)
		begin
			b_next.cnt  = absft_pkg::PREAMBLE_LEN;
			if (b_reg.cnt == absft_pkg::PREAMBLE_LEN - 10'h001 && b_reg.seen != 4'hf)
				b_next.seen = 4'(b_reg.seen + 4'h1);
			else if (b_reg.cnt != absft_pkg::PREAMBLE_LEN - 10'h001)
				b_next.seen = 4'h0;
			b_next.lock = (b_next.seen >= absft_pkg::LOCK_NEED);
		end
		// Period sequencing by counter
		if (b_next.cnt == 10'h000)
		begin
			b_next.ph     = absft_pkg::PH_CTRL;
			b_next.sf_tgl = ~b_reg.sf_tgl;
		end
		else if (b_next.cnt == absft_pkg::CTRL_LEN)
		begin
			b_next.ph     = absft_pkg::PH_DOWN; // Slots right after control
			b_next.bit_i  = 6'h00;
			b_next.slot_i = 6'h00;
		end
		else if (b_next.cnt == cfg.resp_time)
			b_next.ph = absft_pkg::PH_RESP;     // Shared turn-around point
		else if (b_next.cnt == resp_end)
		begin
			b_next.ph     = absft_pkg::PH_UP;   // Slots right after response
			b_next.bit_i  = 6'h00;
			b_next.slot_i = 6'h00;
		end
		case (b_reg.ph)
			absft_pkg::PH_CTRL:
			begin
				// Master drives preamble then zeros to end of control frame
				b_next.oe = cfg.master;
				if (b_reg.cnt < absft_pkg::PREAMBLE_LEN)
					b_next.out = absft_pkg::PREAMBLE_WORD[4'(15 - b_reg.cnt)];
			end
			absft_pkg::PH_RESP:
				b_next.oe = cfg.last_node && b_reg.lock; // Last node answers
			absft_pkg::PH_DOWN, absft_pkg::PH_UP:
			begin
				if (b_reg.slot_i < slot_n)
				begin
					// Master sources downstream, slaves upstream
					b_next.oe  = (b_reg.ph == absft_pkg::PH_DOWN) ? cfg.master : !cfg.master;
					b_next.out = b_reg.cur.data[5'(slot_w - 6'h01 - b_reg.bit_i)];
					b_next.sh  = {b_reg.sh[30:0], li_sync[1]};
					if (b_reg.bit_i == slot_w - 6'h01)
					begin
						// Slot done: store received word, fetch next one
						b_next.bit_i  = 6'h00;
						b_next.slot_i = 6'(b_reg.slot_i + 6'h01);
						if (!b_next.oe && rx_room)
							b_next.wp = 3'(b_reg.wp + 3'h1);
						// Only a driven slot consumes a word, else it would be lost
						if (b_next.oe && tx_have)
						begin
							b_next.cur = txm[b_reg.rp[0]];
							b_next.rp  = 3'(b_reg.rp + 3'h1);
						end
						else if (b_next.oe)
							b_next.cur = '0; // Underrun sends zeros
					end
					else
						b_next.bit_i = 6'(b_reg.bit_i + 6'h01);
				end
			end
			absft_pkg::PH_IDLE: b_next.oe = 1'b0;
			default: b_next.ph = absft_pkg::PH_IDLE;
		endcase
		// After upstream slots the bus falls idle
		if (b_reg.ph == absft_pkg::PH_UP && b_next.ph == absft_pkg::PH_UP
			&& b_reg.slot_i >= slot_n)
			b_next.ph = absft_pkg::PH_IDLE;
		// Gray copies leave flops, so the user clock never samples a glitch
		b_next.wp_g = bin2gray(b_next.wp);
		b_next.rp_g = bin2gray(b_next.rp);
	end

	// Bus side registers
	always_ff @(posedge bclk or posedge rst)
	begin
		if (rst)
		begin
			b_reg    <= '0;
			b_reg.ph <= absft_pkg::PH_IDLE;
		end
		else
		begin
			b_reg <= b_next;
			// Received slot lands in the rx FIFO
			if (b_next.wp != b_reg.wp)
				rxm[b_reg.wp[0]] <= '{slot: b_reg.slot_i[4:0], data: {b_reg.sh[30:0], li_sync[1]}};
		end
	end

	assign line_out = b_reg.out;
	assign line_oe  = b_reg.oe;

	// ----------------------------------------
	// User side FIFO ends
	// ----------------------------------------
	logic [2:0] rwp_u;                           // Rx write pointer in clk
	logic [2:0] trp_u;                           // Tx read pointer in clk
	logic       rx_have;                         // Rx FIFO not empty

	always_comb
	begin
		rwp_u    = gray2bin(u_reg.rwp_s2);
		trp_u    = gray2bin(u_reg.trp_s2);
		tx_ready = (3'(u_reg.twp - trp_u) != 3'h2); // Full stalls the user
		rx_have  = (rwp_u != u_reg.rrp);
		u_next        = u_reg;
		u_next.rwp_s1 = b_reg.wp_g;
		u_next.rwp_s2 = u_reg.rwp_s1;
		u_next.trp_s1 = b_reg.rp_g;
		u_next.trp_s2 = u_reg.trp_s1;
		u_next.tg_s1  = b_reg.sf_tgl;
		u_next.tg_s2  = u_reg.tg_s1;
		u_next.tg_s3  = u_reg.tg_s2;
		u_next.lk_s1  = b_reg.lock;
		u_next.lk_s2  = u_reg.lk_s1;
		if (tx_valid && tx_ready)
			u_next.twp = 3'(u_reg.twp + 3'h1);
		// Output register refills when empty or taken
		if (!u_reg.rv || rx_ready)
		begin
			u_next.rv = rx_have;
			if (rx_have)
			begin
				u_next.rw  = rxm[u_reg.rrp[0]];
				u_next.rrp = 3'(u_reg.rrp + 3'h1);
			end
		end
		// Gray copies registered before they cross to the bus clock
		u_next.twp_g = bin2gray(u_next.twp);
		u_next.rrp_g = bin2gray(u_next.rrp);
	end

	// User side registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			u_reg <= '0;
		else
		begin
			u_reg <= u_next;
			if (tx_valid && tx_ready)
				txm[u_reg.twp[0]] <= tx_word;
		end
	end

	assign rx_valid   = u_reg.rv;
	assign rx_word    = u_reg.rw;
	assign locked     = u_reg.lk_s2;
	assign sf_start   = u_reg.tg_s2 ^ u_reg.tg_s3; // One pulse per superframe
	assign frame_rate = cfg.rate;
endmodule // absft_timing
`default_nettype wire

// ==== absft_pkg.sv ====
// Purpose: Shared constants and types for the superframe timing block
// Assumes: Bus clock period of 1024 cycles per superframe
// Notes:   All offsets, counts and reset values live here
`default_nettype none
package absft_pkg;
	// ----------------------------------------
	// Superframe geometry
	// ----------------------------------------
	localparam int unsigned SF_CYCLES      = 1024;              // Bus clocks per superframe
	localparam logic [9:0]  SF_LAST        = 10'h3ff;           // Last bus clock index
	localparam logic [9:0]  CTRL_LEN       = 10'h040;           // Control frame length
	localparam logic [9:0]  RESP_LEN       = 10'h040;           // Response frame length
	localparam logic [9:0]  RESP_TIME_RST  = 10'h200;           // Default response time
	localparam logic [9:0]  PREAMBLE_LEN   = 10'h010;           // Preamble bits in control frame
	localparam logic [15:0] PREAMBLE_WORD  = 16'hf0a5;          // Preamble pattern
	localparam logic [3:0]  LOCK_NEED      = 4'h3;              // Preambles before lock
	// ----------------------------------------
	// TDM geometry
	// ----------------------------------------
	localparam logic [5:0]  CH_MAX         = 6'h20;             // Up to 32 channels
	localparam logic [5:0]  BITS16         = 6'h10;             // Short channel
	localparam logic [5:0]  BITS32         = 6'h20;             // Long channel
	localparam logic [5:0]  SLOT_W_RST     = 6'h20;             // Default slot width
	// ----------------------------------------
	// Frame rate select
	// ----------------------------------------
	localparam logic        RATE_48K       = 1'b0;              // 48 kHz frame rate
	localparam logic        RATE_44K1      = 1'b1;              // 44.1 kHz frame rate
	localparam int unsigned BCLK_48K_HZ    = 49152000;          // Bus clock at 48 kHz
	localparam int unsigned BCLK_44K1_HZ   = 45158400;          // Bus clock at 44.1 kHz

	// Superframe period phases
	typedef enum logic [4:0] {
		PH_CTRL = 5'h01,   // Control frame with preamble
		PH_DOWN = 5'h02,   // Downstream slots
		PH_RESP = 5'h04,   // Response frame
		PH_UP   = 5'h08,   // Upstream slots
		PH_IDLE = 5'h10    // Nobody drives
	} absft_phase_t;

	// Configuration bundle
	typedef struct packed {
		logic       master;       // Node is bus master
		logic       last_node;    // Node is last in chain
		logic [9:0] resp_time;    // Response time in bus clocks
		logic [5:0] dn_slot_w;    // Downstream slot width
		logic [5:0] up_slot_w;    // Upstream slot width
		logic [5:0] dn_slots;     // Downstream slot count
		logic [5:0] up_slots;     // Upstream slot count
		logic       ch32;         // Channel length 32 when set
		logic       dual16;       // Two 16-channel streams
		logic       rate;         // Frame rate select
	} absft_cfg_t;

	// Word with its slot number
	typedef struct packed {
		logic [4:0]  slot;
		logic [31:0] data;
	} absft_word_t;
endpackage
`default_nettype wire

// ==== absft_timing_sva.sv ====
// Purpose: Concurrent checks on the superframe timing block ports
// Assumes: Node set up as bus master, bus clock 1024 per superframe
// Notes:   Counters carry the long spans; both clock domains checked
`timescale 1ns/1ps
`default_nettype none
module absft_timing_sva
(
	input  wire logic                   clk,         // User clock
	input  wire logic                   rst,         // Async reset, high
	input  wire logic                   bclk,        // Bus clock
	input  wire absft_pkg::absft_cfg_t  cfg,         // Static setup
	input  wire logic                   line_out,    // Line bit
	input  wire logic                   line_oe,     // Line drive enable
	input  wire logic                   rx_valid,    // Word offered
	input  wire logic                   rx_ready,    // Word taken
	input  wire absft_pkg::absft_word_t rx_word,     // Word from bus
	input  wire logic                   locked,      // Lock flag
	input  wire logic                   sf_start,    // Superframe pulse
	input  wire logic                   frame_rate   // Rate echo
);
	logic [13:0] sf_gap_reg;     // User clocks since last pulse
	logic [1:0]  sf_seen_reg;    // Pulses seen, saturates at two
	logic [10:0] oe_gap_reg;     // Bus clocks since last drive start
	logic [1:0]  oe_seen_reg;    // Drive starts seen, saturates at two
	logic        oe_q_reg;       // Drive enable one bus clock ago
	logic [6:0]  run_reg;        // Length of the drive burst, saturates
	// ----------------------------------------
	// Span counters
	// ----------------------------------------
	// First two spans after reset may be cut by frame sync, so skip them
	always_ff @(posedge clk or posedge rst)
		if (rst)
			{sf_gap_reg, sf_seen_reg} <= {14'h0000, 2'h0};
		else
		begin
			sf_gap_reg  <= sf_start ? 14'h0000 : sf_gap_reg + 14'h0001;
			sf_seen_reg <= (sf_start && sf_seen_reg != 2'h2) ? sf_seen_reg + 2'h1 : sf_seen_reg;
		end
	// Bus side: start spacing and burst length
	always_ff @(posedge bclk or posedge rst)
		if (rst)
			{oe_gap_reg, oe_seen_reg, oe_q_reg, run_reg} <= {11'h000, 2'h0, 1'b0, 7'h00};
		else
		begin
			oe_q_reg    <= line_oe;
			oe_gap_reg  <= (line_oe && !oe_q_reg) ? 11'h000 : oe_gap_reg + 11'h001;
			oe_seen_reg <= (line_oe && !oe_q_reg && oe_seen_reg != 2'h2) ? oe_seen_reg + 2'h1
				: oe_seen_reg;
			run_reg     <= !line_oe ? 7'h00 : (run_reg == 7'h7f) ? run_reg : run_reg + 7'h01;
		end
	// ----------------------------------------
	// Preamble pattern, most significant bit first
	// ----------------------------------------
	sequence s_pre_head;
		line_out [*4] ##1 !line_out [*4];
	endsequence
	sequence s_pre_tail;
		line_out ##1 !line_out ##1 line_out ##1 !line_out ##1 !line_out ##1 line_out ##1 !line_out
			##1 line_out;
	endsequence
	property p_preamble;
		@(posedge bclk) disable iff (rst) $rose(line_oe) |-> s_pre_head ##1 s_pre_tail;
	endproperty
	chk_oe_preamble: assert property (p_preamble)
		else $error("control frame preamble pattern wrong");
	chk_oe_period: assert property (@(posedge bclk) disable iff (rst)
		$rose(line_oe) && oe_seen_reg == 2'h2 |-> oe_gap_reg == 11'h3ff)
		else $error("drive starts not 1024 bus clocks apart");
	chk_oe_burst: assert property (@(posedge bclk) disable iff (rst)
		$fell(line_oe) |-> run_reg >= 7'h40)
		else $error("drive burst shorter than control frame");
	chk_sf_pulse: assert property (@(posedge clk) disable iff (rst)
		sf_start |=> !sf_start)
		else $error("superframe pulse longer than one clock");
	chk_sf_period: assert property (@(posedge clk) disable iff (rst)
		sf_start && sf_seen_reg == 2'h2 |-> sf_gap_reg >= 14'h1ffa && sf_gap_reg <= 14'h2004)
		else $error("superframe pulse spacing wrong");
	chk_rate_echo: assert property (@(posedge clk) disable iff (rst)
		frame_rate == cfg.rate)
		else $error("frame rate echo differs from setup");
	chk_rx_hold: assert property (@(posedge clk) disable iff (rst)
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
		else $error("received word dropped while stalled");
	chk_reset_quiet: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> !sf_start && !rx_valid && !locked)
		else $error("outputs active right after reset");
endmodule // absft_timing_sva
`default_nettype wire

// ==== absft_far_end.sv ====
// Purpose: Far side model: host frame sync and the last node's answer
// Assumes: Bus clock made by the bench; shares the default response time
// Notes:   An undriven line toggles each bus clock, never holds a stale bit
`timescale 1ns/1ps
`default_nettype none
module absft_far_end
(
	input  wire logic bclk,       // Bus clock from host
	input  wire logic rst,        // Async reset, high
	input  wire logic line_oe,    // Design drives the line
	output logic      fsync,      // Frame sync pulse
	output logic      line_in     // Line as the design sees it
);
	logic [9:0] pos_reg;          // Position in superframe
	logic       tog_reg;          // Filler for a released line
	// Host keeps a fixed 1024 bus clock spacing
	always_ff @(posedge bclk or posedge rst)
		if (rst)
			{pos_reg, tog_reg} <= {10'h000, 1'b0};
		else
			{pos_reg, tog_reg} <= {pos_reg + 10'h001, ~tog_reg};
	assign fsync = (pos_reg == 10'h000) && !rst;
	// Answer after the shared response time: preamble, then data
	always_comb
		if (line_oe)
			line_in = tog_reg;   // Collision is not modelled
		else if (pos_reg >= absft_pkg::RESP_TIME_RST && pos_reg < 10'h210)
			line_in = absft_pkg::PREAMBLE_WORD[4'hf - pos_reg[3:0]];
		else if (pos_reg >= absft_pkg::RESP_TIME_RST && pos_reg < 10'h300)
			line_in = pos_reg[0] ^ pos_reg[2];
		else
			line_in = tog_reg;   // Idle, nobody drives
endmodule // absft_far_end
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the superframe timing block
// Assumes: Master node, 125 MHz user clock, 64 ns bus clock
// Notes:   Inputs change on falling clock edges only
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                   clk, rst, bclk, fsync, line_in, line_out, line_oe;
	logic                   tx_valid, tx_ready, rx_valid, rx_ready, locked, sf_start, frame_rate;
	absft_pkg::absft_cfg_t  cfg;          // Node setup, changed only in reset
	absft_pkg::absft_word_t tx_word, rx_word;
	int                     mismatches, total_checks;
	initial clk = 1'b0;
	initial bclk = 1'b0;
	always #4 clk = ~clk;
	// Odd offset keeps bus clock edges off the user clock edges
	always
	begin
		#13;
		forever #32 bclk = ~bclk;
	end
	absft_timing uut (.clk(clk), .rst(rst), .bclk(bclk), .cfg(cfg), .fsync(fsync),
		.line_in(line_in), .line_out(line_out), .line_oe(line_oe), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_word(tx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_word(rx_word), .locked(locked), .sf_start(sf_start), .frame_rate(frame_rate));
	absft_far_end far (.bclk(bclk), .rst(rst), .line_oe(line_oe), .fsync(fsync),
		.line_in(line_in));
	// ----------------------------------------
	// Compare and closing tasks
	// ----------------------------------------
	task automatic chk_bit(input string name, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_w16(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic do_reset(input logic rate);
		@(negedge clk);
		rst = 1'b1;
		cfg.rate = rate; // Other fields keep their values
		repeat (20) @(negedge clk);
		chk_bit("reset_quiet", 1'b0, sf_start | rx_valid | line_oe | locked);
		chk_bit("rate_echo", rate, frame_rate);
		rst = 1'b0;
	endtask
	// Push back to back until the two-entry buffer refuses, then drain
	task automatic t_tx_fill;
		int n;
		n = 0;
		tx_valid = 1'b1;
		while (tx_ready === 1'b1 && n < 40)
		begin
			tx_word = {n[4:0], 16'hc0de, n[15:0]};
			n++;
			@(negedge clk);
		end
		tx_valid = 1'b0;
		chk_bit("tx_refused", 1'b1, tx_ready === 1'b0 && n >= 2);
		n = 0;
		while (tx_ready !== 1'b1 && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
		chk_bit("tx_drained", 1'b1, tx_ready);
	endtask
	// Stall the receiver; the offered word must stand until taken
	task automatic t_rx_stall;
		absft_pkg::absft_word_t w;
		int n;
		n = 0;
		while (rx_valid !== 1'b1 && n < 9000)
		begin
			@(negedge clk);
			n++;
		end
		w = rx_word;
		repeat (30) @(negedge clk);
		chk_bit("rx_held", 1'b1, n < 9000 && rx_valid === 1'b1 && rx_word === w);
		// Far end fills upstream slots with a period-8 pattern: every word is b4b4b4b4
		chk_w16("rx_data_hi", 16'hb4b4, w.data[31:16]);
		chk_w16("rx_data_lo", 16'hb4b4, w.data[15:0]);
		chk_w16("rx_slot", 16'h0000, {11'h000, w.slot});
		rx_ready = 1'b1;
		repeat (200) @(negedge clk);
	endtask
	// User clocks between superframe pulses, 1024 bus clocks of 64 ns
	task automatic t_sf_period;
		int n;
		n = 0;
		while (sf_start !== 1'b1 && n < 12000)
		begin
			@(negedge clk);
			n++;
		end
		n = 1;
		@(negedge clk);
		while (sf_start !== 1'b1 && n < 12000)
		begin
			@(negedge clk);
			n++;
		end
		chk_bit("sf_gap", 1'b1, n >= 8188 && n <= 8196);
		chk_bit("locked", 1'b1, locked);
	endtask
	// Preamble bits on the line and spacing of drive starts
	task automatic t_frame;
		logic [15:0] sh;
		logic        prev;
		int          n;
		n = 0;
		prev = 1'b1;
		@(negedge bclk);
		while (!(line_oe === 1'b1 && prev === 1'b0) && n < 3000)
		begin
			prev = line_oe;
			@(negedge bclk);
			n++;
		end
		for (int i = 0; i < 16; i++)
		begin
			sh = {sh[14:0], line_out};
			@(negedge bclk);
		end
		chk_w16("preamble", absft_pkg::PREAMBLE_WORD, sh);
		n = 16;
		prev = 1'b1;
		while (!(line_oe === 1'b1 && prev === 1'b0) && n < 3000)
		begin
			prev = line_oe;
			@(negedge bclk);
			n++;
		end
		chk_bit("oe_period", 1'b1, n == 1024);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		{mismatches, total_checks} = {32'h0, 32'h0};
		{rst, tx_valid, rx_ready, tx_word} = {1'b1, 1'b0, 1'b0, 37'h0};
		cfg = '{master: 1'b1, last_node: 1'b0, resp_time: absft_pkg::RESP_TIME_RST,
			dn_slot_w: absft_pkg::BITS32, up_slot_w: absft_pkg::BITS32, dn_slots: 6'h04,
			up_slots: 6'h04, ch32: 1'b1, dual16: 1'b0, rate: absft_pkg::RATE_48K};
		do_reset(absft_pkg::RATE_48K);
		t_tx_fill();
		t_rx_stall();
		t_sf_period();
		t_frame();
		do_reset(absft_pkg::RATE_44K1);
		t_sf_period();
		wrap_up();
	end
	// Expected run is near 33000 clocks; this leaves margin
	initial
	begin
		repeat (98000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
endmodule // tb
bind absft_timing absft_timing_sva sva_i (.clk(clk), .rst(rst), .bclk(bclk), .cfg(cfg),
	.line_out(line_out), .line_oe(line_oe), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_word(rx_word), .locked(locked), .sf_start(sf_start), .frame_rate(frame_rate));
`default_nettype wire
